// ===== hw/via_pkg.sv
// Constants for the vectored interrupt aggregator.
package via_pkg;
  localparam logic [7:0] STD_IRQ_ENABLE_ADDR = 8'hA8;
  localparam logic [7:0] IRQ_SENSE_ADDR = 8'h88;
  localparam logic [15:0] IRQ_VECTOR_ADDR = 16'hFF92;
  localparam logic [7:0] STD_IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IRQ_VECTOR_RESET = 8'h00;
  localparam logic [7:0] STD_IRQ_ENABLE_WMASK = 8'h9F;
  localparam int EXT0_EN_BIT = 0;
  localparam int TIMER0_EN_BIT = 1;
  localparam int EXT1_EN_BIT = 2;
  localparam int TIMER1_EN_BIT = 3;
  localparam int SERIAL_EN_BIT = 4;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int SENSE_LEVEL_BIT = 0;
  localparam int NUM_STD_SOURCES = 5;
  localparam int NUM_GROUPS = 8;
  localparam int GROUP_SIZE = 8;
  localparam int NUM_SOURCES = 64;
  localparam logic [15:0] EXT0_SERVICE_ADDR = 16'h0003;
  localparam logic [15:0] TIMER0_SERVICE_ADDR = 16'h000B;
  localparam logic [15:0] EXT1_SERVICE_ADDR = 16'h0013;
  localparam logic [15:0] TIMER1_SERVICE_ADDR = 16'h001B;
  localparam logic [15:0] SERIAL_SERVICE_ADDR = 16'h0023;
  localparam logic [15:0] RESET_START_ADDR = 16'h0000;
  typedef enum logic [0:0] {
    VIA_SENSE_EDGE = 1'b0,
    VIA_SENSE_LEVEL = 1'b1
  } via_sense_type;
endpackage : via_pkg

// ===== hw/via_fcfs_group.sv
// One group of eight sources kept in arrival order.
module via_fcfs_group
  import via_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reqEvent,
  input wire logic retire,
  input wire logic [2:0] retireIdx,
  output logic headValid,
  output logic [2:0] headIdx
);
  logic [7:0] pend_q;
  logic [7:0] pend_d;
  logic [7:0] older_q [0:7];
  logic [7:0] older_d [0:7];
  logic [7:0] retireMask;
  logic [7:0] newArr;
  logic [7:0] kept;
  logic cand;

  always_comb begin
    retireMask = retire ? (8'h01 << retireIdx) : 8'h00;
    kept = pend_q & ~retireMask;
    // A request arriving as its source retires counts as a new arrival.
    newArr = reqEvent & ~kept;
    pend_d = kept | reqEvent;
    for (int i = 0; i < GROUP_SIZE; i++) begin
      older_d[i] = older_q[i];
    end
    for (int i = 0; i < GROUP_SIZE; i++) begin
      if (newArr[i]) begin
        for (int j = 0; j < GROUP_SIZE; j++) begin
          older_d[i][j] = newArr[j] && (i < j);
          older_d[j][i] = kept[j] || (newArr[j] && (j < i));
        end
      end
    end
    headValid = 1'b0;
    headIdx = 3'h0;
    for (int i = GROUP_SIZE - 1; i >= 0; i--) begin
      cand = pend_q[i];
      for (int j = 0; j < GROUP_SIZE; j++) begin
        if (pend_q[j] && older_q[j][i]) begin
          cand = 1'b0;
        end
      end
      if (cand) begin
        headValid = 1'b1;
        headIdx = i[2:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_q <= 8'h00;
      for (int i = 0; i < GROUP_SIZE; i++) begin
        older_q[i] <= 8'h00;
      end
    end else begin
      pend_q <= pend_d;
      for (int i = 0; i < GROUP_SIZE; i++) begin
        older_q[i] <= older_d[i];
      end
    end
  end
endmodule : via_fcfs_group

// ===== hw/via_interrupt_aggregator.sv
// Interrupt aggregator with standard enables and the internal vector register.

module via_interrupt_aggregator
  import via_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic xWrite,
  input wire logic xRead,
  input wire logic [15:0] xAddr,
  input wire logic [7:0] xWdata,
  output logic [7:0] xRdata,
  input wire logic [NUM_SOURCES-1:0] periphIrqEvent,
  input wire logic timer0Req,
  input wire logic ext1Req,
  input wire logic timer1Req,
  input wire logic serialReq,
  input wire logic ext0Ack,
  output logic combinedPeripheralIrq_n,
  output logic [NUM_STD_SOURCES-1:0] coreIrqReq,
  output logic [15:0] serviceAddr
);
  logic [7:0] stdIrqEnableReg_q;
  logic [7:0] stdIrqEnableReg_d;
  via_sense_type ext0Sense_q;
  via_sense_type ext0Sense_d;
  logic [7:0] irqVectorReg_q;
  logic [7:0] irqVectorReg_d;
  logic vecValid_q;
  logic vecValid_d;
  logic [7:0] sfrRdata_q;
  logic [7:0] sfrRdata_d;
  logic [7:0] xRdata_q;
  logic [7:0] xRdata_d;
  logic combinedPeripheralIrq_n_q;
  logic combinedPeripheralIrq_n_d;
  logic combinedPrev_q;
  logic combinedPrev_d;
  logic ext0Flag_q;
  logic ext0Flag_d;
  logic [NUM_STD_SOURCES-1:0] coreIrqReq_q;
  logic [NUM_STD_SOURCES-1:0] coreIrqReq_d;
  logic [15:0] serviceAddr_q;
  logic [15:0] serviceAddr_d;
  logic [NUM_GROUPS-1:0] grpValid;
  logic [2:0] grpHead [0:NUM_GROUPS-1];
  logic [NUM_GROUPS-1:0] grpRetire;
  logic vecWrite;
  logic enWrite;
  logic senseWrite;
  logic anyPending;
  logic ext0Req;
  logic [NUM_STD_SOURCES-1:0] rawReq;
  logic [NUM_STD_SOURCES-1:0] enabledReq;

  function automatic logic [7:0] make_vector(input logic [3:0] grp, input logic [2:0] idx);
    // Group and index form the code; the lowest bit stays zero.
    make_vector = {grp, idx, 1'b0};
  endfunction : make_vector

  function automatic logic [3:0] group_of(input int g);
    // Group slot g holds the sources of vector group g plus one.
    group_of = 4'(g + 1);
  endfunction : group_of

  function automatic logic vec_hit(input logic [15:0] a);
    // Only the vector register is mapped in the external space.
    vec_hit = (a == IRQ_VECTOR_ADDR);
  endfunction : vec_hit

  function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] target);
    sfr_hit = (a == target);
  endfunction : sfr_hit

  function automatic logic [NUM_STD_SOURCES-1:0] enabled_requests(input logic [NUM_STD_SOURCES-1:0] req,
    input logic [7:0] en);
    // A cleared global enable masks every source.
    enabled_requests = '0;
    if (en[GLOBAL_EN_BIT]) begin
      enabled_requests = req & en[NUM_STD_SOURCES-1:0];
    end
  endfunction : enabled_requests

  function automatic logic [15:0] std_address(input logic [NUM_STD_SOURCES-1:0] req);
    std_address = RESET_START_ADDR;
    if (req[SERIAL_EN_BIT]) begin
      std_address = SERIAL_SERVICE_ADDR;
    end
    if (req[TIMER1_EN_BIT]) begin
      std_address = TIMER1_SERVICE_ADDR;
    end
    if (req[EXT1_EN_BIT]) begin
      std_address = EXT1_SERVICE_ADDR;
    end
    if (req[TIMER0_EN_BIT]) begin
      std_address = TIMER0_SERVICE_ADDR;
    end
    if (req[EXT0_EN_BIT]) begin
      std_address = EXT0_SERVICE_ADDR;
    end
  endfunction : std_address

  assign vecWrite = xWrite && vec_hit(xAddr);
  assign enWrite = sfrWrite && sfr_hit(sfrAddr, STD_IRQ_ENABLE_ADDR);
  assign senseWrite = sfrWrite && sfr_hit(sfrAddr, IRQ_SENSE_ADDR);

  for (genvar g = 0; g < NUM_GROUPS; g++) begin : gen_group
    assign grpRetire[g] = vecWrite && vecValid_q && (irqVectorReg_q[7:4] == group_of(g));
    via_fcfs_group u_group (
      .clk(clk),
      .reset_n(reset_n),
      .reqEvent(periphIrqEvent[g*GROUP_SIZE +: GROUP_SIZE]),
      .retire(grpRetire[g]),
      .retireIdx(irqVectorReg_q[3:1]),
      .headValid(grpValid[g]),
      .headIdx(grpHead[g])
    );
  end

  always_comb begin
    irqVectorReg_d = IRQ_VECTOR_RESET;
    vecValid_d = 1'b0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (grpValid[g]) begin
        vecValid_d = 1'b1;
        irqVectorReg_d = make_vector(group_of(g), grpHead[g]);
      end
    end
    // Nothing pending leaves the code at zero.
    if (!vecValid_d) begin
      irqVectorReg_d = IRQ_VECTOR_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irqVectorReg_q <= IRQ_VECTOR_RESET;
      vecValid_q <= 1'b0;
    end else begin
      irqVectorReg_q <= irqVectorReg_d;
      vecValid_q <= vecValid_d;
    end
  end

  always_comb begin
    stdIrqEnableReg_d = stdIrqEnableReg_q;
    ext0Sense_d = ext0Sense_q;
    // Reserved bits five and six stay zero.
    if (enWrite) begin
      stdIrqEnableReg_d = sfrWdata & STD_IRQ_ENABLE_WMASK;
    end
    if (senseWrite) begin
      ext0Sense_d = sfrWdata[SENSE_LEVEL_BIT] ? VIA_SENSE_LEVEL : VIA_SENSE_EDGE;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stdIrqEnableReg_q <= STD_IRQ_ENABLE_RESET;
      ext0Sense_q <= VIA_SENSE_EDGE;
    end else begin
      stdIrqEnableReg_q <= stdIrqEnableReg_d;
      ext0Sense_q <= ext0Sense_d;
    end
  end

  always_comb begin
    sfrRdata_d = sfrRdata_q;
    if (sfrRead) begin
      unique case (sfrAddr)
        STD_IRQ_ENABLE_ADDR: begin
          sfrRdata_d = stdIrqEnableReg_q;
        end
        IRQ_SENSE_ADDR: begin
          sfrRdata_d = {7'h00, ext0Sense_q};
        end
        default: begin
          sfrRdata_d = 8'h00;
        end
      endcase
    end
    xRdata_d = xRdata_q;
    if (xRead) begin
      xRdata_d = vec_hit(xAddr) ? {irqVectorReg_q[7:1], 1'b0} : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sfrRdata_q <= 8'h00;
      xRdata_q <= 8'h00;
    end else begin
      sfrRdata_q <= sfrRdata_d;
      xRdata_q <= xRdata_d;
    end
  end

  always_comb begin
    // Any pending internal source drives the combined request.
    anyPending = |grpValid;
    // Held low while anything remains pending.
    combinedPeripheralIrq_n_d = !anyPending;
    combinedPrev_d = combinedPeripheralIrq_n_q;
    ext0Flag_d = ext0Flag_q;
    if (ext0Ack) begin
      ext0Flag_d = 1'b0;
    end
    // Falling edge sets the flag; set beats acknowledge.
    if (combinedPrev_q && !combinedPeripheralIrq_n_q) begin
      ext0Flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      combinedPeripheralIrq_n_q <= 1'b1;
      combinedPrev_q <= 1'b1;
      ext0Flag_q <= 1'b0;
    end else begin
      combinedPeripheralIrq_n_q <= combinedPeripheralIrq_n_d;
      combinedPrev_q <= combinedPrev_d;
      ext0Flag_q <= ext0Flag_d;
    end
  end

  always_comb begin
    if (ext0Sense_q == VIA_SENSE_LEVEL) begin
      ext0Req = !combinedPeripheralIrq_n_q;
    end else begin
      ext0Req = ext0Flag_q;
    end
    // Standard sources in their enable positions.
    rawReq = '0;
    rawReq[EXT0_EN_BIT] = ext0Req;
    rawReq[TIMER0_EN_BIT] = timer0Req;
    rawReq[EXT1_EN_BIT] = ext1Req;
    rawReq[TIMER1_EN_BIT] = timer1Req;
    rawReq[SERIAL_EN_BIT] = serialReq;
    enabledReq = enabled_requests(rawReq, stdIrqEnableReg_q);
    coreIrqReq_d = enabledReq;
    // Service address, start address when idle.
    serviceAddr_d = std_address(enabledReq);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      coreIrqReq_q <= '0;
      serviceAddr_q <= RESET_START_ADDR;
    end else begin
      coreIrqReq_q <= coreIrqReq_d;
      serviceAddr_q <= serviceAddr_d;
    end
  end

  assign sfrRdata = sfrRdata_q;
  assign xRdata = xRdata_q;
  assign combinedPeripheralIrq_n = combinedPeripheralIrq_n_q;
  assign coreIrqReq = coreIrqReq_q;
  assign serviceAddr = serviceAddr_q;
endmodule : via_interrupt_aggregator

// ===== bench/via_agg_properties.sv
// Port assertions for the interrupt aggregator.
module via_agg_checker
  import via_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic xWrite,
  input wire logic xRead,
  input wire logic [15:0] xAddr,
  input wire logic [7:0] xRdata,
  input wire logic [NUM_SOURCES-1:0] periphIrqEvent,
  input wire logic combinedPeripheralIrq_n,
  input wire logic [NUM_STD_SOURCES-1:0] coreIrqReq,
  input wire logic [15:0] serviceAddr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_idleRead;
    xRead && xAddr == IRQ_VECTOR_ADDR && combinedPeripheralIrq_n && $past(combinedPeripheralIrq_n)
      ##1 combinedPeripheralIrq_n;
  endsequence
  sequence s_quiet;
    !combinedPeripheralIrq_n && !xWrite && !$past(xWrite) && !$past(xWrite, 2);
  endsequence
  a_event_lowers: assert property (periphIrqEvent != '0 |-> ##[2:3] !combinedPeripheralIrq_n)
    else $error("event not combined");
  a_pending_holds: assert property (s_quiet |=> !combinedPeripheralIrq_n)
    else $error("request dropped");
  a_retire_rises: assert property ($rose(combinedPeripheralIrq_n) |-> $past(xWrite, 2) || $past(xWrite, 3))
    else $error("request ended unretired");
  a_ext0_addr: assert property (coreIrqReq[0] |-> serviceAddr == EXT0_SERVICE_ADDR)
    else $error("bad ext0 address");
  a_timer0_addr: assert property (coreIrqReq[1:0] == 2'b10 |-> serviceAddr == TIMER0_SERVICE_ADDR)
    else $error("bad timer0 address");
  a_serial_addr: assert property (coreIrqReq == 5'h10 |-> serviceAddr == SERIAL_SERVICE_ADDR)
    else $error("bad serial address");
  a_vector_even: assert property (xRead && xAddr == IRQ_VECTOR_ADDR |=> !xRdata[0] && xRdata[7:4] <= 4'h8)
    else $error("bad vector code");
  a_idle_vector: assert property (s_idleRead |-> xRdata == 8'h00)
    else $error("idle vector not zero");
endmodule : via_agg_checker

bind via_interrupt_aggregator via_agg_checker u_via_agg_checker (.clk, .reset_n, .xWrite, .xRead, .xAddr,
  .xRdata, .periphIrqEvent, .combinedPeripheralIrq_n, .coreIrqReq, .serviceAddr);

// ===== bench/via_core_model.sv
// Core model that reaches the block over its two register buses.
module via_core_model (
  input wire logic clk,
  output logic sfrWrite,
  output logic sfrRead,
  output logic [7:0] sfrAddr,
  output logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  output logic xWrite,
  output logic xRead,
  output logic [15:0] xAddr,
  output logic [7:0] xWdata,
  input wire logic [7:0] xRdata,
  output logic ext0Ack
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {sfrWrite, sfrRead, xWrite, xRead, ext0Ack} = '0;
    {sfrAddr, sfrWdata, xAddr, xWdata} = '0;
  end
  task automatic access(input logic ext, input logic wr, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge clk);
    {sfrWrite, sfrRead, xWrite, xRead} = {wr && !ext, !wr && !ext, wr && ext, !wr && ext};
    {sfrAddr, sfrWdata, xAddr, xWdata} = {a[7:0], d, a, d};
    @(negedge clk);
    q = ext ? xRdata : sfrRdata;
    {sfrWrite, sfrRead, xWrite, xRead} = '0;
    {sfrAddr, sfrWdata, xAddr, xWdata} = ~{sfrAddr, sfrWdata, xAddr, xWdata};
  endtask : access
  task automatic ack();
    @(negedge clk);
    ext0Ack = 1'b1;
    @(negedge clk);
    ext0Ack = 1'b0;
  endtask : ack
endmodule : via_core_model

// ===== bench/via_interrupt_aggregator_tb_top.sv
// Self-checking bench for the interrupt aggregator.
module via_interrupt_aggregator_tb_top
  import via_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n, sfrWrite, sfrRead, xWrite, xRead, ext0Ack, combinedPeripheralIrq_n;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, xWdata, xRdata;
  logic [15:0] xAddr, serviceAddr;
  logic [NUM_SOURCES-1:0] periphIrqEvent;
  logic [NUM_STD_SOURCES-1:0] coreIrqReq;
  logic [3:0] stdReq;
  int err_total = 0;
  int compares = 0;
  via_interrupt_aggregator u_via_interrupt_aggregator (.clk, .reset_n, .sfrWrite, .sfrRead, .sfrAddr,
    .sfrWdata, .sfrRdata, .xWrite, .xRead, .xAddr, .xWdata, .xRdata, .periphIrqEvent,
    .timer0Req(stdReq[0]), .ext1Req(stdReq[1]), .timer1Req(stdReq[2]), .serialReq(stdReq[3]), .ext0Ack,
    .combinedPeripheralIrq_n, .coreIrqReq, .serviceAddr);
  via_core_model u_via_core_model (.clk, .sfrWrite, .sfrRead, .sfrAddr, .sfrWdata, .sfrRdata, .xWrite,
    .xRead, .xAddr, .xWdata, .xRdata, .ext0Ack);
  always #10 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic ext, input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_via_core_model.access(ext, 1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic ext, input logic [15:0] a, output logic [7:0] q);
    u_via_core_model.access(ext, 1'b0, a, 8'h00, q);
  endtask : rd
  task automatic pulse(input logic [NUM_SOURCES-1:0] b);
    @(negedge clk);
    periphIrqEvent = b;
    @(negedge clk);
    periphIrqEvent = '0;
  endtask : pulse
  task automatic drain(input logic [7:0] e [4]);
    logic [7:0] q;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      rd(1'b1, IRQ_VECTOR_ADDR, q);
      chk(16'(q), 16'(e[i]));
      wr(1'b1, IRQ_VECTOR_ADDR, 8'h5A);
    end
  endtask : drain
  task automatic t_reset_state();
    logic [7:0] q;
    rd(1'b0, 16'(STD_IRQ_ENABLE_ADDR), q);
    chk(16'(q), 16'(STD_IRQ_ENABLE_RESET));
    rd(1'b1, IRQ_VECTOR_ADDR, q);
    chk(16'(q), 16'(IRQ_VECTOR_RESET));
    chk(serviceAddr, RESET_START_ADDR);
  endtask : t_reset_state
  task automatic t_std_sources();
    logic [7:0] q;
    logic [15:0] tab [4] = '{TIMER0_SERVICE_ADDR, EXT1_SERVICE_ADDR, TIMER1_SERVICE_ADDR, SERIAL_SERVICE_ADDR};
    wr(1'b0, 16'(STD_IRQ_ENABLE_ADDR), 8'hFF);
    rd(1'b0, 16'(STD_IRQ_ENABLE_ADDR), q);
    chk(16'(q), 16'h009F);
    stdReq = 4'hF;
    wr(1'b0, 16'(STD_IRQ_ENABLE_ADDR), 8'h7F);
    repeat (3) @(negedge clk);
    chk(16'(coreIrqReq), 16'h0000);
    wr(1'b0, 16'(STD_IRQ_ENABLE_ADDR), 8'h9E);
    for (int i = 0; i < 4; i++) begin
      stdReq = 4'h1 << i;
      repeat (3) @(negedge clk);
      chk(16'(coreIrqReq), 16'h0002 << i);
      chk(serviceAddr, tab[i]);
    end
    stdReq = 4'h0;
  endtask : t_std_sources
  task automatic t_priority();
    pulse((64'h1 << 1) | (64'h1 << 18) | (64'h1 << 60));
    drain('{8'h88, 8'h34, 8'h12, 8'h00});
  endtask : t_priority
  task automatic t_arrival();
    pulse(64'h1 << 38);
    pulse(64'h1 << 33);
    drain('{8'h5C, 8'h52, 8'h00, 8'h00});
  endtask : t_arrival
  task automatic t_ext0_sense();
    logic [7:0] q;
    wr(1'b0, 16'(STD_IRQ_ENABLE_ADDR), 8'h81);
    pulse(64'h1 << 40);
    repeat (4) @(negedge clk);
    chk(16'(coreIrqReq), 16'h0001);
    u_via_core_model.ack();
    repeat (3) @(negedge clk);
    chk(16'(coreIrqReq), 16'h0000);
    wr(1'b0, 16'(IRQ_SENSE_ADDR), 8'h01);
    repeat (3) @(negedge clk);
    chk(16'(coreIrqReq), 16'h0001);
    rd(1'b1, IRQ_VECTOR_ADDR, q);
    chk(16'(q), 16'h0060);
    wr(1'b1, IRQ_VECTOR_ADDR, 8'h00);
    repeat (4) @(negedge clk);
    chk(16'(coreIrqReq), 16'h0000);
    chk(16'(combinedPeripheralIrq_n), 16'h0001);
  endtask : t_ext0_sense
  initial begin
    reset_n = 1'b0;
    periphIrqEvent = '0;
    stdReq = 4'h0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    t_reset_state();
    t_std_sources();
    t_priority();
    t_arrival();
    t_ext0_sense();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : via_interrupt_aggregator_tb_top
